//--- fsrc_pkg.sv
/*
 * Shared constants for the flash suspend/resume controller pair:
 * instruction codes, status bit positions, parameter word and timing.
 * Assumes a 250 MHz core clock on both ends.
 */
// ==========================================================
// Package
package fsrc_pkg;
    // Core clock period
    localparam int CORE_PERIOD_NS = 4;
    // Instruction codes
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_RDSTAT = 8'h05;
    localparam logic [7:0] OP_RDPARAM = 8'h5A;
    localparam logic [7:0] OP_PROGRAM = 8'h02;
    localparam logic [7:0] OP_ERASE = 8'h20;
    // Status byte bit positions
    localparam int SR_WIP_BIT = 0;
    localparam int SR_PSUS_BIT = 6;
    localparam int SR_ESUS_BIT = 7;
    // Suspend parameter word, most significant byte first
    localparam logic [31:0] SUSP_PARAM_WORD = 32'h441883CC;
    // Worst-case suspend latency: count 00100b in 10 us units
    localparam logic [1:0] SUSP_LAT_UNITS = 2'h2;
    localparam logic [4:0] SUSP_LAT_COUNT = 5'h04;
    localparam int SUSP_MAX_US = 40;
    localparam int SUSP_MAX_CYC = SUSP_MAX_US * 1000 / CORE_PERIOD_NS;
    // Least resume to suspend interval
    localparam int RESUME_GAP_US = 128;
    localparam int RESUME_GAP_CYC = (RESUME_GAP_US * 1000 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    // Link clock half period in core cycles (160 ns period)
    localparam int SCK_HALF_CYC = 20;
    // Array operation durations
    localparam int ERASE_CYC = 50000;
    localparam int PROG_CYC = 20000;
    // Bytes answered by read instructions
    localparam int STAT_BYTES = 1;
    localparam int PARAM_BYTES = 4;
endpackage : fsrc_pkg

//--- fsrc_link_if.sv
/*
 * Serial link between host controller and flash device.
 * Assumes the host makes sck and cs_n; the device drives miso.
 */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Interface
interface fsrc_link_if;
    logic sck; // Link clock, idle low
    logic cs_n; // Frame select, active low
    logic mosi; // Host to device data
    logic miso; // Device to host data
    // Device end
    modport dev (input sck, input cs_n, input mosi, output miso);
    // Host end
    modport host (output sck, output cs_n, output mosi, input miso);
endinterface : fsrc_link_if
`default_nettype wire

//--- fsrc_dev.sv
/*
 * Flash device end: decodes serial instructions on the link clock,
 * runs erase/program timing, suspend and resume in the core domain.
 * Assumes mode 0 framing: data sampled on rising sck, driven on falling.
 */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Device end
// Behaviour
// - 75h suspends a running erase
// - 7Ah resumes a suspended erase
// - 75h also suspends a running page program
// - 7Ah also resumes a suspended page program
// - Erase suspend completes within 40 us
// - Host waits 128 us from resume to suspend
// - Program suspend completes within 40 us
// - Host waits 128 us after program resume
// - No new erase while erase suspended
// - No read of suspended erase sector
// - No new program while program suspended
// - No read of suspended program page
// - Parameter word reads 44 18 83 CC
// - Status 05h bit 0 shows busy
module fsrc_dev
    import fsrc_pkg::*;
#(
    parameter int ERASE_TIME_CYC = ERASE_CYC,
    parameter int PROG_TIME_CYC = PROG_CYC,
    parameter int SUSP_TIME_CYC = SUSP_MAX_CYC
) (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Serial link
    fsrc_link_if.dev link,
    // Core status
    output logic busy_ff,
    output logic erase_susp_ff,
    output logic prog_susp_ff
);
    // ==========================================================
    // Elaboration checks
    initial begin
        // Suspend must settle inside the worst-case latency
        if (SUSP_TIME_CYC < 1 || SUSP_TIME_CYC > SUSP_MAX_CYC) begin
            $error("fsrc_dev: SUSP_TIME_CYC out of range");
        end
        // Operations need at least one cycle
        if (ERASE_TIME_CYC < 1 || PROG_TIME_CYC < 1) begin
            $error("fsrc_dev: operation time must be positive");
        end
    end

    // Core state encoding
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ERASE = 3'h1,
        ST_PROG = 3'h2,
        ST_SUSPENDING = 3'h3,
        ST_ESUSP = 3'h4,
        ST_PSUSP = 3'h5
    } fsrc_state_t;

    // ==========================================================
    // Link domain signals
    logic [2:0] bit_cnt_ff; // Bit position within the opcode
    logic op_done_ff; // Opcode fully received this frame
    logic [6:0] rx_ff; // Opcode shift register
    logic [7:0] cmd_code_ff; // Last action opcode, held for core
    logic cmd_tgl_ff; // Flips once per action opcode
    logic [31:0] resp_ff; // Answer shift register
    logic miso_ff; // Driven answer bit
    logic [2:0] stat_s1_ff; // Status synchroniser, first stage
    logic [2:0] stat_s2_ff; // Status synchroniser, second stage
    logic [7:0] rx_code; // Opcode including current bit

    // ==========================================================
    // Core domain signals
    logic tgl_s1_ff; // Event synchroniser, first stage
    logic tgl_s2_ff; // Event synchroniser, second stage
    logic tgl_s3_ff; // Edge detect stage
    logic cmd_evt; // One-cycle action request
    fsrc_state_t state_ff; // Operation state
    fsrc_state_t nxt_state;
    logic susp_erase_ff; // Suspended operation was an erase
    logic [31:0] remain_ff; // Cycles left in operation
    logic [31:0] lat_ff; // Cycles left to settle suspend

    assign rx_code = {rx_ff, link.mosi};
    assign link.miso = miso_ff;

    // ==========================================================
    // Link side: opcode capture
    // Bit counter restarts with each frame
    always_ff @(posedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            bit_cnt_ff <= 3'h0;
            op_done_ff <= 1'b0;
        end else if (!op_done_ff) begin
            // Count opcode bits
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin
                op_done_ff <= 1'b1;
            end
        end
    end

    // Opcode shift register
    always_ff @(posedge link.sck) begin
        rx_ff <= rx_code[6:0];
    end

    // Action opcodes pass to core as a toggle event
    always_ff @(posedge link.sck or posedge rst) begin
        if (rst) begin
            cmd_tgl_ff <= 1'b0;
            cmd_code_ff <= 8'h00;
        end else if (!op_done_ff && bit_cnt_ff == 3'h7 &&
                     rx_code != OP_RDSTAT && rx_code != OP_RDPARAM) begin
            cmd_code_ff <= rx_code;
            cmd_tgl_ff <= ~cmd_tgl_ff;
        end
    end

    // Status flags into the link domain
    always_ff @(posedge link.sck) begin
        stat_s1_ff <= {erase_susp_ff, prog_susp_ff, busy_ff};
        stat_s2_ff <= stat_s1_ff;
    end

    // Answer load on last opcode bit, then shift out
    always_ff @(posedge link.sck) begin
        if (!op_done_ff && bit_cnt_ff == 3'h7) begin
            if (rx_code == OP_RDSTAT) begin
                // Status byte with busy in bit 0
                resp_ff <= 32'h00000000;
                resp_ff[24 + SR_WIP_BIT] <= stat_s2_ff[0];
                resp_ff[24 + SR_PSUS_BIT] <= stat_s2_ff[1];
                resp_ff[24 + SR_ESUS_BIT] <= stat_s2_ff[2];
            end else if (rx_code == OP_RDPARAM) begin
                resp_ff <= SUSP_PARAM_WORD;
            end else begin
                resp_ff <= 32'h00000000;
            end
        end else if (op_done_ff) begin
            resp_ff <= {resp_ff[30:0], 1'b0};
        end
    end

    // Drive answer bit on falling sck
    always_ff @(negedge link.sck or posedge link.cs_n) begin
        if (link.cs_n) begin
            miso_ff <= 1'b0;
        end else begin
            miso_ff <= op_done_ff ? resp_ff[31] : 1'b0;
        end
    end

    // ==========================================================
    // Core side: event crossing
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tgl_s1_ff <= 1'b0;
            tgl_s2_ff <= 1'b0;
            tgl_s3_ff <= 1'b0;
        end else begin
            tgl_s1_ff <= cmd_tgl_ff;
            tgl_s2_ff <= tgl_s1_ff;
            tgl_s3_ff <= tgl_s2_ff;
        end
    end

    assign cmd_evt = tgl_s2_ff ^ tgl_s3_ff;

    // ==========================================================
    // Operation state machine
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                // Start operations; stray suspend/resume ignored
                if (cmd_evt && cmd_code_ff == OP_ERASE) begin
                    nxt_state = ST_ERASE;
                end else if (cmd_evt && cmd_code_ff == OP_PROGRAM) begin
                    nxt_state = ST_PROG;
                end
            end
            ST_ERASE, ST_PROG: begin
                // One code suspends either operation
                if (cmd_evt && cmd_code_ff == OP_SUSPEND) begin
                    nxt_state = ST_SUSPENDING;
                end else if (remain_ff <= 32'h1) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_SUSPENDING: begin
                // Settle, then report suspended
                if (lat_ff <= 32'h1) begin
                    nxt_state = susp_erase_ff ? ST_ESUSP : ST_PSUSP;
                end
            end
            ST_ESUSP: begin
                // Only resume leaves; new erase refused
                if (cmd_evt && cmd_code_ff == OP_RESUME) begin
                    nxt_state = ST_ERASE;
                end
            end
            ST_PSUSP: begin
                // Only resume leaves; new program refused
                if (cmd_evt && cmd_code_ff == OP_RESUME) begin
                    nxt_state = ST_PROG;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Remaining work; held across a suspension
    always_ff @(posedge core_clk) begin
        if (rst) begin
            remain_ff <= 32'h0;
        end else if (state_ff == ST_IDLE && nxt_state == ST_ERASE) begin
            remain_ff <= 32'(ERASE_TIME_CYC);
        end else if (state_ff == ST_IDLE && nxt_state == ST_PROG) begin
            remain_ff <= 32'(PROG_TIME_CYC);
        end else if ((state_ff == ST_ERASE || state_ff == ST_PROG) &&
                     nxt_state == state_ff) begin
            remain_ff <= remain_ff - 32'h1;
        end
    end

    // Suspend settle counter and suspended kind
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lat_ff <= 32'h0;
            susp_erase_ff <= 1'b0;
        end else if (nxt_state == ST_SUSPENDING && state_ff != ST_SUSPENDING) begin
            lat_ff <= 32'(SUSP_TIME_CYC);
            susp_erase_ff <= (state_ff == ST_ERASE);
        end else if (state_ff == ST_SUSPENDING) begin
            lat_ff <= lat_ff - 32'h1;
        end
    end

    // Registered status outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy_ff <= 1'b0;
            erase_susp_ff <= 1'b0;
            prog_susp_ff <= 1'b0;
        end else begin
            busy_ff <= (nxt_state == ST_ERASE) || (nxt_state == ST_PROG) ||
                       (nxt_state == ST_SUSPENDING);
            erase_susp_ff <= (nxt_state == ST_ESUSP);
            prog_susp_ff <= (nxt_state == ST_PSUSP);
        end
    end
endmodule : fsrc_dev
`default_nettype wire

//--- fsrc_host.sv
/*
 * Host controller end: frames one instruction at a time on the link,
 * makes sck by dividing its core clock, and gathers read answers.
 * Assumes the device answers on falling sck after the opcode.
 */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host end
module fsrc_host
    import fsrc_pkg::*;
#(
    parameter int HALF_CYC = SCK_HALF_CYC,
    parameter int GAP_CYC = RESUME_GAP_CYC
) (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Serial link
    fsrc_link_if.host link,
    // Request
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    output logic cmd_ready_ff,
    output logic cmd_refused_ff,
    // Answer
    output logic rsp_valid_ff,
    output logic [31:0] rsp_data_ff
);
    // ==========================================================
    // Elaboration checks
    initial begin
        if (HALF_CYC < 4 || GAP_CYC < 1) begin
            $error("fsrc_host: HALF_CYC below 4 or GAP_CYC below 1");
        end
    end

    typedef enum logic [1:0] {
        HS_IDLE = 2'h0,
        HS_XFER = 2'h1,
        HS_DONE = 2'h2
    } fsrc_hstate_t;

    fsrc_hstate_t hst_ff; // Framer state
    logic [15:0] div_ff; // Half period counter
    logic [5:0] fall_ff; // Falling edges done
    logic [5:0] total_ff; // Edge pairs in this frame
    logic [7:0] tx_ff; // Opcode shift register
    logic [31:0] rx_ff; // Answer shift register
    logic sck_ff, cs_n_ff, mosi_ff;
    logic miso_s1_ff, miso_s2_ff; // Answer pin synchroniser
    logic esus_ff, psus_ff; // Host view of suspended state
    logic last_erase_ff; // Last started operation was an erase
    logic [31:0] gap_ff; // Resume to suspend spacing
    logic half_end;
    logic refuse;

    assign link.sck = sck_ff;
    assign link.cs_n = cs_n_ff;
    assign link.mosi = mosi_ff;
    assign half_end = (div_ff == 16'(HALF_CYC - 1));

    // Requests that would break the suspend protocol
    always_comb begin
        refuse = 1'b0;
        if (cmd_code == OP_SUSPEND && gap_ff != 32'h0) begin
            refuse = 1'b1;
        end
        if (esus_ff && cmd_code == OP_ERASE) begin
            refuse = 1'b1;
        end
        if (psus_ff && cmd_code == OP_PROGRAM) begin
            refuse = 1'b1;
        end
    end

    // Answer pin synchroniser
    always_ff @(posedge core_clk) begin
        miso_s1_ff <= link.miso;
        miso_s2_ff <= miso_s1_ff;
    end

    // ==========================================================
    // Framer
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hst_ff <= HS_IDLE;
            div_ff <= 16'h0;
            fall_ff <= 6'h0;
            total_ff <= 6'h8;
            tx_ff <= 8'h00;
            rx_ff <= 32'h0;
            sck_ff <= 1'b0;
            cs_n_ff <= 1'b1;
            mosi_ff <= 1'b0;
            cmd_ready_ff <= 1'b1;
            cmd_refused_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= 32'h0;
        end else begin
            cmd_refused_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
            case (hst_ff)
                HS_IDLE: begin
                    // Take a request and open a frame
                    if (cmd_valid && refuse) begin
                        cmd_refused_ff <= 1'b1;
                    end else if (cmd_valid) begin
                        cmd_ready_ff <= 1'b0;
                        cs_n_ff <= 1'b0;
                        mosi_ff <= cmd_code[7];
                        tx_ff <= {cmd_code[6:0], 1'b0};
                        fall_ff <= 6'h0;
                        div_ff <= 16'h0;
                        rx_ff <= 32'h0;
                        if (cmd_code == OP_RDPARAM) begin
                            total_ff <= 6'(8 + 8 * PARAM_BYTES);
                        end else if (cmd_code == OP_RDSTAT) begin
                            total_ff <= 6'(8 + 8 * STAT_BYTES);
                        end else begin
                            total_ff <= 6'h8;
                        end
                        hst_ff <= HS_XFER;
                    end
                end
                HS_XFER: begin
                    // Toggle sck each half period
                    div_ff <= half_end ? 16'h0 : div_ff + 16'h1;
                    if (half_end) begin
                        sck_ff <= ~sck_ff;
                        if (sck_ff) begin
                            // Falling edge: sample, then shift out
                            fall_ff <= fall_ff + 6'h1;
                            mosi_ff <= tx_ff[7];
                            tx_ff <= {tx_ff[6:0], 1'b0};
                            if (fall_ff >= 6'h8) begin
                                rx_ff <= {rx_ff[30:0], miso_s2_ff};
                            end
                            if (fall_ff + 6'h1 == total_ff) begin
                                hst_ff <= HS_DONE;
                            end
                        end
                    end
                end
                HS_DONE: begin
                    // Close frame after a half period
                    div_ff <= half_end ? 16'h0 : div_ff + 16'h1;
                    if (half_end) begin
                        cs_n_ff <= 1'b1;
                        mosi_ff <= 1'b0;
                        cmd_ready_ff <= 1'b1;
                        rsp_valid_ff <= (total_ff != 6'h8);
                        rsp_data_ff <= rx_ff;
                        hst_ff <= HS_IDLE;
                    end
                end
                default: begin
                    hst_ff <= HS_IDLE;
                end
            endcase
        end
    end

    // Host view of suspension and resume spacing
    always_ff @(posedge core_clk) begin
        if (rst) begin
            esus_ff <= 1'b0;
            psus_ff <= 1'b0;
            last_erase_ff <= 1'b0;
            gap_ff <= 32'h0;
        end else if (hst_ff == HS_IDLE && cmd_valid && !refuse) begin
            if (cmd_code == OP_RESUME) begin
                esus_ff <= 1'b0;
                psus_ff <= 1'b0;
                gap_ff <= 32'(GAP_CYC);
            end else if (cmd_code == OP_ERASE) begin
                last_erase_ff <= 1'b1;
            end else if (cmd_code == OP_PROGRAM) begin
                last_erase_ff <= 1'b0;
            end else if (cmd_code == OP_SUSPEND) begin
                // Suspend applies to the operation last started
                esus_ff <= last_erase_ff;
                psus_ff <= !last_erase_ff;
            end
        end else if (gap_ff != 32'h0) begin
            gap_ff <= gap_ff - 32'h1;
        end
    end
endmodule : fsrc_host
`default_nettype wire

//--- fsrc_checker.sv
/* Checker for the link framing and the device status of the suspend pair.
   Assumes sck is a divided core_clk, so every link edge is seen at core_clk. */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module fsrc_checker #(
    parameter int MAX_BUSY = 100
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Link
    input wire logic sck,
    input wire logic cs_n,
    // Device status
    input wire logic busy_ff,
    input wire logic erase_susp_ff,
    input wire logic prog_susp_ff
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    int busy_run_ff; // Consecutive busy cycles
    // Length of the current busy stretch
    always_ff @(posedge core_clk) begin
        busy_run_ff <= (rst || !busy_ff) ? 0 : busy_run_ff + 1;
    end
    busy_bound_a: assert property (busy_run_ff <= MAX_BUSY)
        else $error("busy stretch too long");
    susp_excl_a: assert property (!(erase_susp_ff && prog_susp_ff))
        else $error("both suspend flags set");
    esus_rise_a: assert property ($rose(erase_susp_ff) |-> $past(busy_ff, 2))
        else $error("erase suspended without running");
    psus_rise_a: assert property ($rose(prog_susp_ff) |-> $past(busy_ff, 2))
        else $error("program suspended without running");
    susp_idle_a: assert property ((erase_susp_ff || prog_susp_ff) |-> !busy_ff)
        else $error("busy while suspended");
    esus_fall_a: assert property ($fell(erase_susp_ff) |-> ##[0:2] busy_ff)
        else $error("erase resume did not restart");
    psus_fall_a: assert property ($fell(prog_susp_ff) |-> ##[0:2] busy_ff)
        else $error("program resume did not restart");
    idle_sck_a: assert property (cs_n |-> !sck)
        else $error("link clock runs outside frame");
    frame_start_a: assert property ($fell(cs_n) |-> !sck [*8])
        else $error("link clock too early in frame");
endmodule : fsrc_checker
`default_nettype wire

//--- fsrc_tb.sv
/* Testbench: host and device joined by the link, compared with a model.
   Assumes shortened array and suspend times set by parameters below. */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Testbench
module fsrc_tb;
    import fsrc_pkg::*;
    localparam int ERASE_T = 4000; // Shortened erase time
    localparam int PROG_T = 3000; // Shortened program time
    localparam int SUSP_T = 20; // Shortened suspend settle
    localparam int GAP_T = 400; // Shortened resume gap
    logic core_clk, rst, cmd_valid, cmd_ready_ff, cmd_refused_ff, rsp_valid_ff;
    logic busy_ff, erase_susp_ff, prog_susp_ff, r;
    logic [7:0] cmd_code, op;
    logic [31:0] rsp_data_ff, d;
    int fail_count, comparisons, n, m_busy, m_esus, m_psus; // Counters and model
    int tick, t0; // Free-running cycle count and a mark in it
    fsrc_link_if link_i ();
    fsrc_dev #(.ERASE_TIME_CYC(ERASE_T), .PROG_TIME_CYC(PROG_T), .SUSP_TIME_CYC(SUSP_T))
        fsrc_dev_i (.core_clk(core_clk), .rst(rst), .link(link_i.dev), .busy_ff(busy_ff),
        .erase_susp_ff(erase_susp_ff), .prog_susp_ff(prog_susp_ff));
    fsrc_host #(.HALF_CYC(SCK_HALF_CYC), .GAP_CYC(GAP_T)) fsrc_host_i (.core_clk(core_clk),
        .rst(rst), .link(link_i.host), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_ready_ff(cmd_ready_ff), .cmd_refused_ff(cmd_refused_ff),
        .rsp_valid_ff(rsp_valid_ff), .rsp_data_ff(rsp_data_ff));
    fsrc_checker #(.MAX_BUSY(ERASE_T + SUSP_T + 8)) fsrc_checker_i (.core_clk(core_clk),
        .rst(rst), .sck(link_i.sck), .cs_n(link_i.cs_n), .busy_ff(busy_ff),
        .erase_susp_ff(erase_susp_ff), .prog_susp_ff(prog_susp_ff));
    // Core clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // Cycle count for latency checks
    always @(posedge core_clk) tick <= tick + 1;
    // Verdict and end of run
    task automatic summarize();
        if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    // Exhausted wait
    task automatic bail();
        fail_count++;
        summarize();
    endtask : bail
    // Compare seen against expected
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // One request through the host, waiting for its end
    task automatic do_cmd(input logic [7:0] code, output logic refd, output logic [31:0] dat);
        logic left;
        refd = 1'b0;
        left = 1'b0;
        dat = 32'h0000_0000;
        for (int i = 0; cmd_ready_ff !== 1'b1; i++) begin
            if (i > 5000) bail();
            @(negedge core_clk);
        end
        cmd_valid = 1'b1;
        cmd_code = code;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        repeat (5000) begin
            if (cmd_refused_ff === 1'b1) refd = 1'b1;
            if (rsp_valid_ff === 1'b1) dat = rsp_data_ff;
            if (cmd_ready_ff === 1'b0) left = 1'b1;
            if (refd || (left && cmd_ready_ff === 1'b1)) begin
                // Let an edge pass so cmd_valid is not set twice in one step
                if (refd) @(negedge core_clk);
                return;
            end
            @(negedge core_clk);
        end
        bail();
    endtask : do_cmd
    // Status read and status pins against the model
    task automatic st();
        logic sr;
        logic [31:0] sd;
        do_cmd(OP_RDSTAT, sr, sd);
        check({24'h0, sd[7:0]}, {24'h0, m_esus[0], m_psus[0], 5'h00, m_busy[0]});
        check({29'h0, busy_ff, erase_susp_ff, prog_susp_ff},
              {29'h0, m_busy[0], m_esus[0], m_psus[0]});
    endtask : st
    // Count cycles until the device is idle
    task automatic wait_idle(output int cyc);
        for (cyc = 0; busy_ff !== 1'b0; cyc++) begin
            if (cyc > 20000) bail();
            @(negedge core_clk);
        end
    endtask : wait_idle
    // Main sequence
    initial begin
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        {fail_count, comparisons, m_busy, m_esus, m_psus} = '0;
        void'($urandom(32'h03C4));
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        st();
        do_cmd(OP_RDPARAM, r, d);
        check(d, 32'h4418_83CC);
        // Erase then program: run, suspend, blocked op, resume, early suspend
        for (int k = 0; k < 2; k++) begin
            op = (k == 1) ? OP_PROGRAM : OP_ERASE;
            do_cmd(op, r, d);
            m_busy = 1;
            st();
            repeat ($urandom_range(800)) @(negedge core_clk);
            t0 = tick;
            do_cmd(OP_SUSPEND, r, d);
            check({31'h0, r}, 32'h0);
            wait_idle(n);
            // Frame of 8 sck periods, settle time, crossing slack
            check(32'(tick - t0 <= 16 * SCK_HALF_CYC + SUSP_T + 8), 32'h1);
            m_busy = 0;
            if (k == 1) m_psus = 1;
            else m_esus = 1;
            // Status reads while suspended; a new op of the same kind is refused
            st();
            do_cmd(op, r, d);
            check({31'h0, r}, 32'h1);
            st();
            do_cmd(OP_RESUME, r, d);
            {m_busy, m_esus, m_psus} = {32'd1, 32'd0, 32'd0};
            do_cmd(OP_SUSPEND, r, d);
            check({31'h0, r}, 32'h1);
            st();
            wait_idle(n);
            m_busy = 0;
            st();
        end
        // Stray resume when idle; the suspend after the status read is past the host resume gap and is ignored by the idle device
        do_cmd(OP_RESUME, r, d);
        st();
        do_cmd(OP_SUSPEND, r, d);
        st();
        summarize();
    end
endmodule : fsrc_tb
`default_nettype wire
